/* hw/ulp_ahb_slave.sv */
// AHB-Lite slave front end: captures the address phase, answers in
// the data phase with zero wait states and always OKAY.
// Assumes single word transfers from one master.
`timescale 1ns/10ps
module ulp_ahb_slave (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic wr_pulse,
  output logic rd_hit,
  output logic hit
);
  typedef struct packed {
    logic wr;
    logic hit;
  } ulp_ahb_st_t;
  ulp_ahb_st_t st_ff, nxt_st;

  // Latch the address phase when the bus is ready
  always_comb begin
    nxt_st = st_ff;
    if (hready) begin
      nxt_st.wr = hsel && htrans[1] && hwrite;
      nxt_st.hit = haddr[11:0] == ulp_pkg::CFG1_OFFSET && hsize == 3'h2;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = 1'b1; // No wait states needed
  assign hresp = 1'b0;
  assign wr_pulse = st_ff.wr && st_ff.hit;
  // Address phase decode, so read data can be registered for the data phase
  assign rd_hit = hready && hsel && htrans[1] && !hwrite;
  assign hit = haddr[11:0] == ulp_pkg::CFG1_OFFSET && hsize == 3'h2;
endmodule

/* hw/ulp_link_cfg.sv */
// USB link power and timing configuration register and its controls.
// Assumes image values arrive with a load strobe from the config loader.
`timescale 1ns/10ps
module ulp_link_cfg (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic image_load,
  input wire logic image_valid,
  input wire ulp_pkg::ulp_cfg_t image_cfg,
  input wire logic usb_reset,
  input wire logic lite_reset,
  input wire logic reset_protect,
  input wire logic host_u1_feature,
  input wire logic full_speed,
  output ulp_pkg::ulp_ctl_t ctl
);
  typedef struct packed {
    ulp_pkg::ulp_cfg_t cfg;
    ulp_pkg::ulp_cfg_t image;
    ulp_pkg::ulp_ctl_t ctl;
    logic [31:0] rdata;
  } ulp_state_t;

  ulp_state_t st_ff, nxt_st;
  logic wr_pulse;
  logic rd_hit;
  logic hit;
  logic [7:0] fs_tenths;
  ulp_pkg::ulp_cfg_t reset_cfg;

  ulp_ahb_slave u_slave (
    .clock(clock),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_pulse(wr_pulse),
    .rd_hit(rd_hit),
    .hit(hit)
  );

  ulp_timeout_calc u_calc (
    .trim(st_ff.cfg.fullspeed_gap_timeout_trim),
    .tenths(fs_tenths)
  );

  // Register word as software sees it; reserved bits stay zero
  function automatic logic [31:0] pack_word(input ulp_pkg::ulp_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ulp_pkg::U1_SELF_BIT] = c.u1_self_initiate_enable;
    w[ulp_pkg::U1_HOST_BIT] = c.u1_host_request_accept;
    w[ulp_pkg::LTM_BIT] = c.latency_tolerance_msg_enable;
    w[ulp_pkg::FS_TRIM_LSB +: ulp_pkg::FS_TRIM_W] = c.fullspeed_gap_timeout_trim;
    w[ulp_pkg::HS_TRIM_LSB +: ulp_pkg::HS_TRIM_W] = c.highspeed_gap_timeout_trim;
    return w;
  endfunction

  // Fallback values when no image has been loaded
  always_comb begin
    reset_cfg.u1_self_initiate_enable = ulp_pkg::U1_SELF_RST;
    reset_cfg.u1_host_request_accept = ulp_pkg::U1_HOST_RST;
    reset_cfg.latency_tolerance_msg_enable = ulp_pkg::LTM_RST;
    reset_cfg.fullspeed_gap_timeout_trim = ulp_pkg::FS_TRIM_RST;
    reset_cfg.highspeed_gap_timeout_trim = ulp_pkg::HS_TRIM_RST;
  end

  // Next state: image capture, link resets, software writes, outputs
  always_comb begin
    nxt_st = st_ff;
    if (image_load) begin
      nxt_st.image = image_valid ? image_cfg : reset_cfg;
      nxt_st.cfg = nxt_st.image;
    end else if (usb_reset || lite_reset) begin
      // Protected enables keep their value while protection is on
      nxt_st.cfg = st_ff.image;
      if (reset_protect) begin
        nxt_st.cfg.u1_self_initiate_enable = st_ff.cfg.u1_self_initiate_enable;
        nxt_st.cfg.u1_host_request_accept = st_ff.cfg.u1_host_request_accept;
        nxt_st.cfg.latency_tolerance_msg_enable =
          st_ff.cfg.latency_tolerance_msg_enable;
      end
    end else if (wr_pulse) begin
      // Only defined fields take write data
      nxt_st.cfg.u1_self_initiate_enable = hwdata[ulp_pkg::U1_SELF_BIT];
      nxt_st.cfg.u1_host_request_accept = hwdata[ulp_pkg::U1_HOST_BIT];
      nxt_st.cfg.latency_tolerance_msg_enable = hwdata[ulp_pkg::LTM_BIT];
      nxt_st.cfg.fullspeed_gap_timeout_trim =
        hwdata[ulp_pkg::FS_TRIM_LSB +: ulp_pkg::FS_TRIM_W];
      nxt_st.cfg.highspeed_gap_timeout_trim =
        hwdata[ulp_pkg::HS_TRIM_LSB +: ulp_pkg::HS_TRIM_W];
    end
    // Read word taken in the address phase so hrdata comes from a flop;
    // using the next value forwards a write whose data phase is this cycle
    nxt_st.rdata = (rd_hit && hit) ? pack_word(nxt_st.cfg) : 32'h0000_0000;
    // Controls from current settings; self-start also needs the host U1 feature
    nxt_st.ctl.u1_self_start_allow =
      st_ff.cfg.u1_self_initiate_enable && host_u1_feature;
    nxt_st.ctl.u1_host_accept = st_ff.cfg.u1_host_request_accept;
    nxt_st.ctl.ltm_msg_allow = st_ff.cfg.latency_tolerance_msg_enable;
    nxt_st.ctl.trim_to_ctrl = full_speed ? st_ff.cfg.fullspeed_gap_timeout_trim
                                         : st_ff.cfg.highspeed_gap_timeout_trim;
    nxt_st.ctl.fs_timeout_tenths = fs_tenths;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff.cfg <= {ulp_pkg::U1_SELF_RST, ulp_pkg::U1_HOST_RST, ulp_pkg::LTM_RST,
                    ulp_pkg::FS_TRIM_RST, ulp_pkg::HS_TRIM_RST};
      st_ff.image <= {ulp_pkg::U1_SELF_RST, ulp_pkg::U1_HOST_RST, ulp_pkg::LTM_RST,
                      ulp_pkg::FS_TRIM_RST, ulp_pkg::HS_TRIM_RST};
      st_ff.ctl <= '0;
      st_ff.rdata <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Read data stands in the data phase only, zero otherwise
  assign hrdata = st_ff.rdata;
  assign ctl = st_ff.ctl;
endmodule

/* hw/ulp_pkg.sv */
// Package for the USB link power and timing configuration block.
// Assumes a single 100 MHz core clock and an AHB-Lite register port.
package ulp_pkg;
  // Register map
  localparam logic [11:0] CFG1_OFFSET = 12'h084;
  // Field positions
  localparam int U1_SELF_BIT = 10;
  localparam int U1_HOST_BIT = 9;
  localparam int LTM_BIT = 8;
  localparam int FS_TRIM_LSB = 4;
  localparam int FS_TRIM_W = 3;
  localparam int HS_TRIM_LSB = 13;
  localparam int HS_TRIM_W = 3;
  // Fallback defaults when no image is loaded
  localparam logic U1_SELF_RST = 1'h0;
  localparam logic U1_HOST_RST = 1'h1;
  localparam logic LTM_RST = 1'h0;
  localparam logic [2:0] FS_TRIM_RST = 3'h0;
  localparam logic [2:0] HS_TRIM_RST = 3'h0;
  // Timing in tenths of a full-speed bit time
  localparam logic [7:0] FS_BASE_MIN_TENTHS = 8'ha0;
  localparam logic [7:0] FS_BASE_MAX_TENTHS = 8'hb4;
  localparam logic [7:0] FS_BASE_TENTHS = 8'haa;
  localparam logic [7:0] FS_PER_PHYCLK_TENTHS = 8'h02;
  // High-speed bit times per 60 MHz PHY clock
  localparam logic [7:0] HS_PER_PHYCLK_BITS = 8'h08;

  // Stored configuration fields
  typedef struct packed {
    logic u1_self_initiate_enable;
    logic u1_host_request_accept;
    logic latency_tolerance_msg_enable;
    logic [2:0] fullspeed_gap_timeout_trim;
    logic [2:0] highspeed_gap_timeout_trim;
  } ulp_cfg_t;

  // Outputs toward the device controller
  typedef struct packed {
    logic u1_self_start_allow;
    logic u1_host_accept;
    logic ltm_msg_allow;
    logic [2:0] trim_to_ctrl;
    logic [7:0] fs_timeout_tenths;
  } ulp_ctl_t;
endpackage

/* hw/ulp_timeout_calc.sv */
// Full-speed inter-packet timeout with PHY delay trim added.
// Assumes a 60 MHz PHY clock, the only rate supported.
`timescale 1ns/10ps
module ulp_timeout_calc #(
  parameter logic [7:0] BASE_TENTHS = ulp_pkg::FS_BASE_TENTHS
) (
  input wire logic [2:0] trim,
  output logic [7:0] tenths
);
  // Refuse a base outside the standard full-speed window at elaboration
  if (BASE_TENTHS < ulp_pkg::FS_BASE_MIN_TENTHS ||
      BASE_TENTHS > ulp_pkg::FS_BASE_MAX_TENTHS) begin : g_bad_base
    $error("base timeout outside 16 to 18 bit times");
  end

  // Each 60 MHz PHY clock is two tenths of a bit time
  assign tenths = BASE_TENTHS + 8'(trim) * ulp_pkg::FS_PER_PHYCLK_TENTHS;
endmodule

/* tb/test_usb_link_power_timing_cfg.sv */
// Bench for the link config block: AHB-Lite calls with expected controls.
// Assumes one bus master; the host model supplies link state.
`timescale 1ns/10ps
module test_usb_link_power_timing_cfg;
  localparam logic [31:0] CFG_A = {20'h0, ulp_pkg::CFG1_OFFSET};
  logic clock = 1'h0, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic image_load = 1'h0, image_valid = 1'h0, usb_reset = 1'h0, lite_reset = 1'h0;
  logic reset_protect = 1'h0, u1_req = 1'h0, fs_req = 1'h1;
  logic hreadyout, hresp, host_u1_feature, full_speed;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, w;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  ulp_pkg::ulp_cfg_t image_cfg = '0;
  ulp_pkg::ulp_ctl_t ctl;
  int err_count = 0, samples_checked = 0;
  always #5 clock = ~clock;
  ulp_link_cfg uut (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .image_load,
    .image_valid, .image_cfg, .usb_reset, .lite_reset, .reset_protect,
    .host_u1_feature, .full_speed, .ctl);
  ulp_host_model host (.clock, .rst_b, .u1_req, .fs_req, .host_u1_feature,
    .full_speed);
  task wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One single transfer; never assumes the wait count
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // Controls expected from a stored word and the requested link state
  function automatic ulp_pkg::ulp_ctl_t mk(input logic [31:0] c);
    mk = {c[10] & u1_req, c[9], c[8], fs_req ? c[6:4] : c[15:13],
      ulp_pkg::FS_BASE_TENTHS + {4'h0, c[6:4], 1'h0}};
  endfunction
  // Let link state settle, read the word back, compare it and the controls
  task cc(input logic [31:0] c);
    repeat (3) @(posedge clock);
    xfer(1'h0, CFG_A, 32'h0);
    chk("cfg word", c, rd);
    chk("response", 32'h0, {31'h0, hresp});
    chk("controls", {18'h0, mk(c)}, {18'h0, ctl});
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'h1;
    @(posedge clock);
    cc(32'h200);
    xfer(1'h1, CFG_A, 32'hffff_ffff);
    cc(32'he770);
    for (int i = 0; i < 4; i++) begin
      u1_req <= i[0];
      fs_req <= i[1];
      cc(32'he770);
    end
    // Trims and enables walk every code; the two trims always differ and speed toggles
    for (int i = 0; i < 8; i++) begin
      w = {16'h0, ~i[2:0], 2'h0, i[2:0], 1'h0, i[2:0], 4'h0};
      fs_req <= i[0];
      xfer(1'h1, CFG_A, w);
      cc(w);
    end
    // Non-word size and unmapped address are both refused
    hsize <= 3'h0;
    xfer(1'h1, CFG_A, 32'h0);
    hsize <= 3'h2;
    xfer(1'h1, 32'h88, 32'hffff_ffff);
    xfer(1'h0, 32'h88, 32'h0);
    chk("unmapped read", 32'h0, rd);
    cc(32'h770);
    image_cfg <= 9'h16a;
    image_valid <= 1'h1;
    image_load <= 1'h1;
    @(posedge clock);
    image_load <= 1'h0;
    cc(32'h4550);
    xfer(1'h1, CFG_A, 32'h0);
    usb_reset <= 1'h1;
    @(posedge clock);
    usb_reset <= 1'h0;
    cc(32'h4550);
    xfer(1'h1, CFG_A, 32'h200);
    reset_protect <= 1'h1;
    lite_reset <= 1'h1;
    @(posedge clock);
    lite_reset <= 1'h0;
    cc(32'h4250);
    // Load with no image present falls back to the built-in defaults
    image_valid <= 1'h0;
    image_load <= 1'h1;
    @(posedge clock);
    image_load <= 1'h0;
    cc(32'h200);
    wrap_up;
  end
  // Whole run is about 135 clocks; this cuts a hang short
  initial begin
    #20us;
    err_count++;
    wrap_up;
  end
endmodule

/* tb/ulp_host_model.sv */
// Host downstream port model: U1 feature grant and link speed.
// Assumes the bench requests changes; each lands one clock later.
`timescale 1ns/10ps
module ulp_host_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic u1_req,
  input wire logic fs_req,
  output logic host_u1_feature,
  output logic full_speed
);
  // Grants are registered, so the device never sees a mid-cycle change
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      host_u1_feature <= 1'h0;
      full_speed <= 1'h1;
    end else begin
      host_u1_feature <= u1_req;
      full_speed <= fs_req;
    end
  end
endmodule

/* tb/ulp_link_cfg_props.sv */
// Checker for the link config block: read-back word against controls.
// Assumes registered controls that follow the stored word by one clock.
`timescale 1ns/10ps
module ulp_link_cfg_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic image_load,
  input wire logic usb_reset,
  input wire logic lite_reset,
  input wire logic host_u1_feature,
  input wire logic full_speed,
  input wire ulp_pkg::ulp_ctl_t ctl
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic rd_dp_ff;
  logic [2:0] quiet_ff;
  // Read data phase marker, and cycles since anything could move the word
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_dp_ff <= 1'h0;
      quiet_ff <= 3'h0;
    end else begin
      rd_dp_ff <= hsel && hready && htrans[1] && !hwrite && hsize == 3'h2
        && haddr[11:0] == ulp_pkg::CFG1_OFFSET;
      quiet_ff <= (image_load || usb_reset || lite_reset || (hsel && hwrite && htrans[1]))
        ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h4};
    end
  end
  AST_SELF_START: assert property (rd_dp_ff |=>
    ctl.u1_self_start_allow == ($past(hrdata[10]) && $past(host_u1_feature)))
    else $error("self U1 start wrong");
  AST_HOST_ACCEPT: assert property (rd_dp_ff |=>
    ctl.u1_host_accept == $past(hrdata[9])) else $error("host U1 accept wrong");
  AST_LTM: assert property (rd_dp_ff |=>
    ctl.ltm_msg_allow == $past(hrdata[8])) else $error("latency msg enable wrong");
  AST_STEER: assert property (rd_dp_ff |=> ctl.trim_to_ctrl ==
    ($past(full_speed) ? $past(hrdata[6:4]) : $past(hrdata[15:13])))
    else $error("trim steering wrong");
  AST_TENTHS: assert property ($past(full_speed) && $past(rst_b) |->
    ctl.fs_timeout_tenths == ulp_pkg::FS_BASE_TENTHS + {4'h0, ctl.trim_to_ctrl, 1'h0})
    else $error("timeout tenths wrong");
  AST_BASE: assert property ($past(full_speed) && $past(rst_b) |->
    ctl.fs_timeout_tenths - {4'h0, ctl.trim_to_ctrl, 1'h0} inside {[8'ha0:8'hb4]})
    else $error("timeout base out of range");
  AST_RSV: assert property (hrdata[7] == 1'h0 && hrdata[3:2] == 2'h0)
    else $error("reserved bits not zero");
  AST_QUIET: assert property (quiet_ff == 3'h4 |->
    $stable(ctl.u1_host_accept) && $stable(ctl.ltm_msg_allow))
    else $error("enable moved without cause");
endmodule
bind ulp_link_cfg ulp_link_cfg_props chk (.clock, .rst_b, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hready, .hrdata, .image_load, .usb_reset, .lite_reset,
  .host_u1_feature, .full_speed, .ctl);
